// file: core/uls_defines.vh
// constants for the uart line status block
// assumes a 32-bit apb slave with one aligned word per register
`ifndef ULS_DEFINES_VH
`define ULS_DEFINES_VH

// --------------------------------------------------------------
// register byte offsets
// --------------------------------------------------------------
`define ULS_OFF_LSTAT 8'h00
`define ULS_OFF_CTRL 8'h04
`define ULS_OFF_ISTAT 8'h08
`define ULS_OFF_IMASK 8'h0C

// --------------------------------------------------------------
// line status bit positions
// --------------------------------------------------------------
`define ULS_B_DR 0
`define ULS_B_OE 1
`define ULS_B_PE 2
`define ULS_B_FE 3
`define ULS_B_BI 4
`define ULS_B_THRE 5
`define ULS_B_TEMT 6
`define ULS_B_FERR 7

// --------------------------------------------------------------
// control bit positions
// --------------------------------------------------------------
`define ULS_C_FIFO 0
`define ULS_C_THRIE 1

// --------------------------------------------------------------
// reset values and defaults
// --------------------------------------------------------------
`define ULS_LSTAT_RST 8'h60
`define ULS_CTRL_RST 2'h0
`define ULS_INT_RST 8'h00
`define ULS_BRK_CYCLES 3472
`define ULS_BRK_W 16

`endif

// file: core/uls_line_status.v
// uart line status register with break detector and apb access
// assumes datapath strobes on pclk; rx_pin is asynchronous
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "uls_defines.vh"

module uls_line_status #(
  parameter BRK_CYCLES = `ULS_BRK_CYCLES
) (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  input wire tx_load,
  input wire tx_move,
  input wire tx_shift_busy,
  input wire tx_fifo_empty,
  input wire rx_pin,
  input wire rx_done,
  input wire rx_frame_err,
  input wire rx_parity_err,
  input wire rx_fifo_full,
  input wire rx_avail,
  input wire rx_head_frame_err,
  input wire rx_head_parity_err,
  input wire rx_head_break,
  input wire rx_fifo_err_any,
  output reg rx_drop,
  output reg brk_push,
  output reg [7:0] line_status_reg,
  output wire tx_irq,
  output wire irq
);

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  wire setup = psel & ~penable;
  wire acc = psel & penable & ce;
  wire hit_lstat = (paddr == `ULS_OFF_LSTAT);
  wire hit_ctrl = (paddr == `ULS_OFF_CTRL);
  wire hit_ist = (paddr == `ULS_OFF_ISTAT);
  wire hit_imk = (paddr == `ULS_OFF_IMASK);
  wire mapped = hit_lstat | hit_ctrl | hit_ist | hit_imk;
  wire rd_lstat = acc & ~pwrite & hit_lstat;
  wire rd_ist = acc & ~pwrite & hit_ist;
  wire wr_ctrl = acc & pwrite & hit_ctrl;
  wire wr_imk = acc & pwrite & hit_imk;

  // ------------------------------------------------------------
  // apb response, no wait states while enabled
  // ------------------------------------------------------------
  assign pready = ce;
  assign pslverr = psel & penable & ~mapped;

  reg [1:0] ctrl_r;
  reg [7:0] istat_r;
  wire [7:0] istat_nxt;
  reg [7:0] imask_r;
  wire fifo_mode = ctrl_r[`ULS_C_FIFO];

  // ------------------------------------------------------------
  // receive line synchroniser and break detector
  // ------------------------------------------------------------
  reg rx_s1_r;
  reg rx_s2_r;
  reg [`ULS_BRK_W-1:0] brk_cnt_r;
  reg brk_seen_r;
  reg brk_evt;

  always @* begin
    brk_evt = ~rx_s2_r & ~brk_seen_r & (brk_cnt_r == BRK_CYCLES[`ULS_BRK_W-1:0] - 1'b1);
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      brk_cnt_r <= {`ULS_BRK_W{1'b0}};
      brk_seen_r <= 1'b0;
      brk_push <= 1'b0;
    end else if (ce) begin
      rx_s1_r <= rx_pin;
      rx_s2_r <= rx_s1_r;
      if (rx_s2_r) begin
        brk_cnt_r <= {`ULS_BRK_W{1'b0}};
        brk_seen_r <= 1'b0;
      end else if (!brk_seen_r) begin
        brk_cnt_r <= brk_cnt_r + 1'b1;
        if (brk_evt)
          brk_seen_r <= 1'b1;
      end
      brk_push <= brk_evt & fifo_mode;
    end
  end

  // ------------------------------------------------------------
  // line status bits
  // ------------------------------------------------------------
  reg oe_r;
  reg pe_r;
  reg fe_r;
  reg bi_r;
  reg thre_r;
  reg ferr_r;
  reg thre_nxt;
  wire ovr_evt = rx_done & rx_fifo_full;

  always @* begin
    thre_nxt = thre_r;
    if (tx_load)
      thre_nxt = 1'b0;
    else if (fifo_mode & tx_fifo_empty)
      thre_nxt = 1'b1;
    else if (!fifo_mode & tx_move)
      thre_nxt = 1'b1;
  end

  // ------------------------------------------------------------
  // overrun flag; set wins, a read clears only what it reported
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_r <= 1'b0;
      rx_drop <= 1'b0;
    end else if (ce) begin
      rx_drop <= ovr_evt;
      if (ovr_evt)
        oe_r <= 1'b1;
      else if (rd_lstat & prdata[`ULS_B_OE])
        oe_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // parity flag of the last character
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pe_r <= 1'b0;
    else if (ce) begin
      if (rx_done & ~rx_fifo_full & rx_parity_err)
        pe_r <= 1'b1;
      else if ((rd_lstat & prdata[`ULS_B_PE]) | (rx_done & ~rx_fifo_full))
        pe_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // framing flag of the last character
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      fe_r <= 1'b0;
    else if (ce) begin
      if (rx_done & ~rx_fifo_full & rx_frame_err)
        fe_r <= 1'b1;
      else if ((rd_lstat & prdata[`ULS_B_FE]) | (rx_done & ~rx_fifo_full))
        fe_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // break flag
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      bi_r <= 1'b0;
    else if (ce) begin
      if (brk_evt)
        bi_r <= 1'b1;
      else if (rd_lstat & prdata[`ULS_B_BI])
        bi_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // collected fifo error flag
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ferr_r <= 1'b0;
    else if (ce) begin
      if (fifo_mode & rx_fifo_err_any)
        ferr_r <= 1'b1;
      else if ((rd_lstat & prdata[`ULS_B_FERR]) | ~fifo_mode)
        ferr_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // holding register empty flag
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      thre_r <= 1'b1;
    else if (ce)
      thre_r <= thre_nxt;
  end

  // status word; no write path exists for it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      line_status_reg <= `ULS_LSTAT_RST;
    else if (ce) begin
      line_status_reg[`ULS_B_DR] <= rx_avail;
      line_status_reg[`ULS_B_OE] <= oe_r;
      line_status_reg[`ULS_B_PE] <= fifo_mode ? rx_head_parity_err : pe_r;
      line_status_reg[`ULS_B_FE] <= fifo_mode ? rx_head_frame_err : fe_r;
      line_status_reg[`ULS_B_BI] <= fifo_mode ? (rx_head_break | bi_r) : bi_r;
      line_status_reg[`ULS_B_THRE] <= thre_r;
      line_status_reg[`ULS_B_TEMT] <= (fifo_mode ? tx_fifo_empty : thre_r) & ~tx_shift_busy;
      line_status_reg[`ULS_B_FERR] <= ferr_r;
    end
  end

  // ------------------------------------------------------------
  // transmit interrupt request
  // ------------------------------------------------------------
  assign tx_irq = line_status_reg[`ULS_B_THRE] & ctrl_r[`ULS_C_THRIE];

  // ------------------------------------------------------------
  // control, interrupt status and mask
  // ------------------------------------------------------------
  wire [7:0] ev;
  assign ev[`ULS_B_DR] = rx_done & ~rx_fifo_full;
  assign ev[`ULS_B_OE] = ovr_evt;
  assign ev[`ULS_B_PE] = rx_done & rx_parity_err;
  assign ev[`ULS_B_FE] = rx_done & rx_frame_err;
  assign ev[`ULS_B_BI] = brk_evt;
  assign ev[`ULS_B_THRE] = thre_nxt & ~thre_r;
  assign ev[`ULS_B_TEMT] = 1'b0;
  assign ev[`ULS_B_FERR] = fifo_mode & rx_fifo_err_any & ~ferr_r;

  // events in the read cycle survive the clear
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_ist
      assign istat_nxt[gi] = ev[gi] | (istat_r[gi] & ~rd_ist);
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `ULS_CTRL_RST;
      istat_r <= `ULS_INT_RST;
      imask_r <= `ULS_INT_RST;
    end else if (ce) begin
      if (wr_ctrl)
        ctrl_r <= pwdata[1:0];
      if (wr_imk)
        imask_r <= pwdata[7:0];
      istat_r <= istat_nxt;
    end
  end

  assign irq = |(istat_r & imask_r);

  // ------------------------------------------------------------
  // read data, latched in the setup cycle
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (ce & setup & ~pwrite) begin
      if (hit_lstat)
        prdata <= {24'h000000, line_status_reg};
      else if (hit_ctrl)
        prdata <= {30'h00000000, ctrl_r};
      else if (hit_ist)
        prdata <= {24'h000000, istat_nxt};
      else if (hit_imk)
        prdata <= {24'h000000, imask_r};
      else
        prdata <= 32'h00000000;
    end
  end

endmodule // uls_line_status

// file: dv/tb_uls_line_status.sv
// testbench for the line status block
// assumes the host model and the bound checker
`timescale 1ns/100ps
module tb_uls_line_status;
  logic pclk = 0, presetn = 0, ce = 1, tx_load = 0, tx_move = 0, tx_shift_busy = 0, tx_fifo_empty = 1;
  logic rx_pin = 1, rx_done = 0, rx_frame_err = 0, rx_parity_err = 0, rx_fifo_full = 0, rx_avail = 0;
  logic rx_fifo_err_any = 0, psel, penable, pwrite, pready, pslverr, rx_drop, brk_push, tx_irq, irq;
  logic [7:0] paddr, lstat;
  logic err_seen = 0;
  logic [31:0] pwdata, prdata, q;
  int n_mismatch = 0, compares = 0, n_brk = 0;
  // ctrl, busy, fifo empty, avail, load, move; expect bit6, bit5, bit0, tx_irq
  logic [10:0] rows [6] = '{11'h4A0, 11'h5D7, 11'h08C, 11'h620, 11'h785, 11'h28C};
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) if (brk_push) n_brk <= n_brk + 1;
  always @(posedge pclk) if (psel && penable && pready) err_seen <= pslverr;
  uls_host u_uls_host (.pclk(pclk), .pready(pready), .prdata(prdata), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  uls_line_status #(.BRK_CYCLES(8)) u_uls_line_status (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .tx_load(tx_load), .tx_move(tx_move), .tx_shift_busy(tx_shift_busy),
    .tx_fifo_empty(tx_fifo_empty), .rx_pin(rx_pin), .rx_done(rx_done), .rx_frame_err(rx_frame_err),
    .rx_parity_err(rx_parity_err), .rx_fifo_full(rx_fifo_full), .rx_avail(rx_avail),
    .rx_head_frame_err(1'b0), .rx_head_parity_err(1'b0), .rx_head_break(1'b0),
    .rx_fifo_err_any(rx_fifo_err_any), .rx_drop(rx_drop), .brk_push(brk_push), .line_status_reg(lstat),
    .tx_irq(tx_irq), .irq(irq));
  // ------
  // helpers
  // ------
  task chk(input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task rw(input logic w, input logic [7:0] a, input logic [31:0] d);
    u_uls_host.xfer(w, a, d, q);
  endtask
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task results;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ------
  // tests
  // ------
  initial begin
    cyc(12);
    chk(lstat, 8'h60);
    presetn <= 1;
    foreach (rows[i]) begin
      rw(1, 8'h04, rows[i][10:9]);
      {tx_shift_busy, tx_fifo_empty, rx_avail, tx_load, tx_move} <= rows[i][8:4];
      cyc(1);
      {tx_load, tx_move} <= 2'h0;
      cyc(3);
      chk({lstat[6:5], lstat[0], tx_irq}, rows[i][3:0]);
      $display("row %0d done", i);
    end
    {rx_done, rx_fifo_full} <= 2'h3;
    cyc(1);
    rx_done <= 0;
    #1 chk(rx_drop, 1);
    cyc(2);
    chk({lstat[1], irq}, 2'h2);
    rw(1, 8'h0C, 32'h2);
    #1 chk(irq, 1);
    rw(0, 8'h08, 0);
    #1 chk({q[1], irq}, 2'h2);
    rw(0, 8'h00, 0);
    cyc(2);
    chk({q[1], lstat[1]}, 2'h2);
    $display("overrun done");
    {rx_fifo_full, rx_pin} <= 2'h0;
    cyc(6);
    chk(lstat[4], 0);
    cyc(24);
    chk({lstat[4], n_brk[1:0]}, 3'h5);
    rx_pin <= 1;
    rw(0, 8'h00, 0);
    cyc(3);
    chk(lstat[4], 0);
    rx_fifo_err_any <= 1;
    cyc(3);
    chk(lstat[7], 1);
    rx_fifo_err_any <= 0;
    rw(0, 8'h00, 0);
    cyc(2);
    chk({q[7], lstat[7]}, 2'h2);
    $display("break and error done");
    rw(1, 8'h04, 0);
    for (int k = 3; k >= 0; k -= 3) begin
      {rx_done, rx_frame_err, rx_parity_err} <= {1'b1, k[1:0]};
      cyc(1);
      rx_done <= 0;
      cyc(2);
      chk(lstat[3:2], k[1:0]);
    end
    rw(1, 8'h00, 32'hFF);
    rw(0, 8'h00, 0);
    chk(q & 32'h9F, 0);
    rw(0, 8'h10, 0);
    chk(q, 0);
    cyc(1);
    chk(err_seen, 1);
    ce <= 0;
    {rx_done, rx_parity_err} <= 2'h3;
    cyc(3);
    chk({pready, lstat[2]}, 0);
    {ce, rx_done, rx_parity_err} <= 3'h4;
    cyc(3);
    chk(lstat[2], 0);
    $display("enable and slave error done");
    {presetn, rx_avail} <= 2'h1;
    cyc(2);
    chk(lstat, 8'h60);
    $display("hand tests done");
    results;
  end
  initial begin
    #50000;
    n_mismatch++;
    results;
  end
endmodule // tb_uls_line_status

// file: dv/uls_host.sv
// apb host model reading and writing the status block
// assumes pready sampled at rising edges of pclk
`timescale 1ns/100ps
module uls_host (
  input wire pclk,
  input wire pready,
  input wire [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  // ------
  // transfer
  // ------
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (!pready) @(posedge pclk);
    q = prdata;
    {psel, penable} <= 2'h0;
  endtask
endmodule // uls_host

// file: dv/uls_line_status_sva.sv
// checker for the line status block
// assumes one clock pclk, presetn active low, ce held high
`timescale 1ns/100ps
module uls_line_status_sva (
  input wire pclk, presetn, tx_load, tx_move, tx_shift_busy, tx_fifo_empty,
  input wire rx_avail, rx_done, rx_fifo_full, rx_drop, brk_push, tx_irq,
  input wire [7:0] line_status_reg
);
  // ------
  // status checks
  // ------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence ovr_ev; rx_done && rx_fifo_full; endsequence
  sequence mv_ev; tx_move && !tx_load && tx_fifo_empty ##1 !tx_load; endsequence
  dr_set_a: assert property (rx_avail |=> line_status_reg[0])
    else $error("ready low");
  dr_clr_a: assert property (!rx_avail |=> !line_status_reg[0])
    else $error("ready high");
  thre_clr_a: assert property (tx_load ##1 !tx_move |=> !line_status_reg[5])
    else $error("thre kept");
  thre_set_a: assert property (mv_ev |=> line_status_reg[5])
    else $error("thre not set");
  temt_busy_a: assert property (tx_shift_busy |=> !line_status_reg[6])
    else $error("temt while busy");
  tx_irq_a: assert property (tx_irq |-> line_status_reg[5])
    else $error("irq without thre");
  ovr_drop_a: assert property (ovr_ev |=> rx_drop ##1 line_status_reg[1])
    else $error("overrun missed");
  brk_once_a: assert property (brk_push |=> !brk_push [*8])
    else $error("break pushed twice");
endmodule // uls_line_status_sva

bind uls_line_status uls_line_status_sva u_sva (.pclk(pclk), .presetn(presetn), .tx_load(tx_load),
  .tx_move(tx_move), .tx_shift_busy(tx_shift_busy), .tx_fifo_empty(tx_fifo_empty), .rx_avail(rx_avail),
  .rx_done(rx_done), .rx_fifo_full(rx_fifo_full), .rx_drop(rx_drop), .brk_push(brk_push),
  .tx_irq(tx_irq), .line_status_reg(line_status_reg));
